/* File: pcg_pkg.sv */
// shared constants, encodings and carriers for the gauge host sequencer
package pcg_pkg;

  // clock rate and times
  localparam int CLK_MHZ        = 20;
  localparam int BUS_LOW_TIME_US = 2000;
  localparam int BUS_LOW_CYCLES  = BUS_LOW_TIME_US * CLK_MHZ;
  localparam int INIT_TIME_US    = 100;
  localparam int INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
  localparam int FINISH_TIME_US  = 500;
  localparam int FINISH_CYCLES   = FINISH_TIME_US * CLK_MHZ;

  // serial addressing
  localparam logic [6:0] DEV_ADDR       = 7'h55;
  localparam int         CMD_LIMIT_BIT  = 7;
  localparam logic [6:0] CTL_LO_ADDR    = 7'h00;
  localparam logic [6:0] CTL_HI_ADDR    = 7'h01;
  localparam logic [6:0] CHARGE_LO_ADDR = 7'h02;
  localparam logic [6:0] CHARGE_HI_ADDR = 7'h03;
  localparam logic [6:0] FLAGS_ADDR     = 7'h0a;
  localparam logic [6:0] HEALTH_ADDR    = 7'h2e;

  // control subcommands
  localparam logic [15:0] SUB_BEGIN = 16'h0011;
  localparam logic [15:0] SUB_END   = 16'h0012;

  // reset values
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] CHARGE_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MODE_CHARGE  = 2'h0,
    MODE_HEALTH  = 2'h1,
    MODE_SERVICE = 2'h2,
    MODE_RSVD    = 2'h3
  } pcg_mode_t;

  localparam pcg_mode_t MODE_DEFAULT = MODE_CHARGE;

  // battery flags byte layout
  typedef struct packed {
    logic [4:0] spare;
    logic       service_end;
    logic       gauge_done;
    logic       init_complete;
  } pcg_flags_t;

  // reserved code falls back to the shipped mode
  function automatic pcg_mode_t decode_mode(input logic [1:0] sel);
    pcg_mode_t m;
    m = MODE_DEFAULT;
    case (sel)
      2'h1:    m = MODE_HEALTH;
      2'h2:    m = MODE_SERVICE;
      default: m = MODE_CHARGE;
    endcase
    return m;
  endfunction

endpackage

/* File: pcg_cmd_mem.sv */
// command location store with registered read, cleared on power-down
`timescale 1ns/100ps
`default_nettype none
module pcg_cmd_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk_sys_in,
  input  wire logic          reset_in,
  // write side
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // read side
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);

  logic [DW-1:0]    mem_q [2**AW];
  logic [2**AW-1:0] valid_q;
  logic [2**AW-1:0] valid_d;
  logic [DW-1:0]    rd_q;
  logic [DW-1:0]    rd_d;

  // valid bits stand in for clearing the array: nothing survives power-off
  always_comb
  begin
    valid_d = valid_q;
    if (wr_en_in)
    begin
      valid_d[wr_addr_in] = 1'b1;
    end
    rd_d = valid_q[rd_addr_in] ? mem_q[rd_addr_in] : '0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      valid_q <= '0;
      rd_q    <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      rd_q    <= rd_d;
    end
  end

  assign rd_data_out = rd_q;

endmodule
`default_nettype wire

/* File: pcg_bus_watch.sv */
// bus-stuck timer: release after a long low, sleep if still held outside
`timescale 1ns/100ps
`default_nettype none
module pcg_bus_watch #(
  parameter int LOW_CYC = 40000
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // bus lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // results
  output logic      release_out,
  output logic      sleep_out
);

  localparam int CW = $clog2(LOW_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          rel_q;
  logic          rel_d;
  logic          sleep_q;
  logic          sleep_d;
  logic          line_low;

  always_comb
  begin
    line_low = ~scl_in | ~sda_in;
    cnt_d    = cnt_q;
    rel_d    = rel_q;
    sleep_d  = sleep_q;
    if (!line_low)
    begin
      cnt_d   = '0;
      rel_d   = 1'b0;
      sleep_d = 1'b0;
    end
    else if (rel_q)
    begin
      // own drive is already off, so a low now is someone else
      sleep_d = 1'b1;
    end
    else if (cnt_q == CW'(LOW_CYC - 1))
    begin
      rel_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      cnt_q   <= '0;
      rel_q   <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      rel_q   <= rel_d;
      sleep_q <= sleep_d;
    end
  end

  assign release_out = rel_q;
  assign sleep_out   = sleep_q;

endmodule
`default_nettype wire

/* File: pcg_sequencer.sv */
// gauge host sequencer: serial slave, power gating, gauging start/stop
`timescale 1ns/100ps
`default_nettype none
// Contract
// - in a write, ack command and first data byte, nack all later bytes
// - read pointer wraps from the top location to location zero
// - release both bus lines after the bus-low timeout
// - line still low after release puts the serial engine to sleep
// - enable pin low: everything off, no state kept (calibration_allowed_out still follows the mode pin)
// - mode field: 0 charge total, 1 health, 2 service end
// - charge mode totals discharge while gauging, gives no health results
// - charge mode is the default and the only calibration mode
// - after power-up, init flag set and alert pulled low
// - reading battery flags releases the alert
// - charge total counts from the latest gauging-begin
// - after gauging-end, finish work, set done flag, pull alert low
// - health mode end stores lifetime data and runs threshold checks
// - service mode done presents the service-end flag in battery flags
// - pointer advances whenever a data byte is acknowledged
// - nack a command byte addressing above the top location
module pcg_sequencer
  import pcg_pkg::*;
#(
  parameter int         BUS_LOW_CYC = BUS_LOW_CYCLES,
  parameter int         INIT_CYC    = INIT_CYCLES,
  parameter int         FINISH_CYC  = FINISH_CYCLES,
  parameter logic [6:0] DEVICE_ADDR = DEV_ADDR
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  // power and mode
  input  wire logic       gauge_power_enable_in,
  input  wire logic [1:0] gauging_mode_select_in,
  // measurement results
  input  wire logic       discharge_tick_in,
  input  wire logic [7:0] health_percent_in,
  input  wire logic       service_end_decision_in,
  // serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_n_out,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // status
  output logic            alert_n_out,
  output logic            init_complete_flag_out,
  output logic            gauge_done_out,
  output logic            service_end_flag_out,
  output logic            gauging_active_out,
  output logic            calibration_allowed_out,
  output logic            lifetime_store_out,
  output logic            threshold_check_out,
  output logic            bus_released_out,
  output logic            serial_sleep_out
);

  typedef enum {I_IDLE, I_ADDR, I_CMD, I_WR, I_ACK, I_RD, I_RACK} pcg_i2c_t;
  typedef enum {G_INIT, G_IDLE, G_ACTIVE, G_FINISH} pcg_gauge_t;

  localparam int MAXC = (INIT_CYC > FINISH_CYC) ? INIT_CYC : FINISH_CYC;
  localparam int GW   = $clog2(MAXC + 1);

  logic       rst;
  pcg_mode_t  mode;
  logic       bus_release;
  logic       serial_sleep;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  logic       mem_we;
  logic       flags_read;
  logic       sub_valid;
  logic       begin_cmd;
  logic       end_cmd;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  pcg_flags_t flags;

  // serial engine state
  pcg_i2c_t   state_q, state_d;
  pcg_i2c_t   after_q, after_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [6:0] ptr_q, ptr_d;
  logic       sda_low_q, sda_low_d;
  logic       wr_seen_q, wr_seen_d;
  logic [7:0] ctl_lo_q, ctl_lo_d;
  logic [7:0] ctl_hi_q, ctl_hi_d;
  logic       scl_q;
  logic       sda_q;

  // gauging state
  pcg_gauge_t g_state_q, g_state_d;
  logic [GW-1:0] g_cnt_q, g_cnt_d;
  logic       init_q, init_d;
  logic       done_q, done_d;
  logic       svc_end_q, svc_end_d;
  logic       alert_q, alert_d;
  logic       life_q, life_d;
  logic       thr_q, thr_d;
  logic [15:0] total_q, total_d;

  // enable low holds every flop except the command memory array in reset
  assign rst  = reset_in | ~gauge_power_enable_in;
  assign mode = decode_mode(gauging_mode_select_in);

  pcg_bus_watch #(
    .LOW_CYC (BUS_LOW_CYC)
  ) u_watch (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (rst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .release_out (bus_release),
    .sleep_out   (serial_sleep)
  );

  pcg_cmd_mem #(
    .AW (7),
    .DW (8)
  ) u_mem (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (rst),
    .wr_en_in    (mem_we),
    .wr_addr_in  (ptr_q),
    .wr_data_in  (shift_q),
    .rd_addr_in  (ptr_q),
    .rd_data_out (mem_rdata)
  );

  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign start_det = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;

  always_comb
  begin
    flags               = '0;
    flags.init_complete = init_q;
    flags.gauge_done    = done_q;
    flags.service_end   = svc_end_q;
    // two-byte total has no snapshot; host reads low then high while idle
    case (ptr_q)
      FLAGS_ADDR:     rd_byte = flags;
      CHARGE_LO_ADDR: rd_byte = total_q[7:0];
      CHARGE_HI_ADDR: rd_byte = total_q[15:8];
      HEALTH_ADDR:    rd_byte = (mode == MODE_CHARGE) ? BYTE_RESET
                                                      : health_percent_in;
      default:        rd_byte = mem_rdata;
    endcase
  end

  always_comb
  begin
    state_d    = state_q;
    after_d    = after_q;
    bit_cnt_d  = bit_cnt_q;
    shift_d    = shift_q;
    ptr_d      = ptr_q;
    sda_low_d  = sda_low_q;
    wr_seen_d  = wr_seen_q;
    ctl_lo_d   = ctl_lo_q;
    ctl_hi_d   = ctl_hi_q;
    mem_we     = 1'b0;
    flags_read = 1'b0;
    sub_valid  = 1'b0;
    if (bus_release || serial_sleep)
    begin
      state_d   = I_IDLE;
      sda_low_d = 1'b0;
    end
    else if (start_det)
    begin
      state_d   = I_ADDR;
      bit_cnt_d = 4'h0;
      sda_low_d = 1'b0;
    end
    else if (stop_det)
    begin
      state_d   = I_IDLE;
      sda_low_d = 1'b0;
    end
    else
    begin
      case (state_q)
        I_ADDR, I_CMD, I_WR:
        begin
          if (scl_rise)
          begin
            shift_d   = {shift_q[6:0], sda_in};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == 4'h8)
          begin
            bit_cnt_d = 4'h0;
            state_d   = I_ACK;
            if (state_q == I_ADDR)
            begin
              if (shift_q[7:1] == DEVICE_ADDR)
              begin
                sda_low_d = 1'b1;
                after_d   = shift_q[0] ? I_RD : I_CMD;
              end
              else
              begin
                state_d = I_IDLE;
              end
            end
            else if (state_q == I_CMD)
            begin
              after_d = I_IDLE;
              if (!shift_q[CMD_LIMIT_BIT])
              begin
                sda_low_d = 1'b1;
                ptr_d     = shift_q[6:0];
                wr_seen_d = 1'b0;
                after_d   = I_WR;
              end
            end
            else
            begin
              after_d = I_WR;
              if (!wr_seen_q)
              begin
                sda_low_d = 1'b1;
                wr_seen_d = 1'b1;
                mem_we    = 1'b1;
                ptr_d     = ptr_q + 7'h01;
                if (ptr_q == CTL_LO_ADDR)
                begin
                  ctl_lo_d = shift_q;
                end
                if (ptr_q == CTL_HI_ADDR)
                begin
                  ctl_hi_d  = shift_q;
                  sub_valid = 1'b1;
                end
              end
            end
          end
        end
        I_ACK:
        begin
          if (scl_fall)
          begin
            sda_low_d = 1'b0;
            state_d   = after_q;
            if (after_q == I_RD)
            begin
              shift_d    = {rd_byte[6:0], 1'b0};
              sda_low_d  = ~rd_byte[7];
              bit_cnt_d  = 4'h1;
              flags_read = (ptr_q == FLAGS_ADDR);
            end
          end
        end
        I_RD:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == 4'h8)
            begin
              sda_low_d = 1'b0;
              state_d   = I_RACK;
            end
            else
            begin
              sda_low_d = ~shift_q[7];
              shift_d   = {shift_q[6:0], 1'b0};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end
        end
        I_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_in)
            begin
              state_d = I_IDLE;
            end
            else
            begin
              // seven-bit pointer rolls from the top to zero
              ptr_d   = ptr_q + 7'h01;
              state_d = I_ACK;
              after_d = I_RD;
            end
          end
        end
        default:
        begin
          state_d = I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst)
    begin
      state_q   <= I_IDLE;
      after_q   <= I_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= BYTE_RESET;
      ptr_q     <= 7'h00;
      sda_low_q <= 1'b0;
      wr_seen_q <= 1'b0;
      ctl_lo_q  <= BYTE_RESET;
      ctl_hi_q  <= BYTE_RESET;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end
    else
    begin
      state_q   <= state_d;
      after_q   <= after_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      ptr_q     <= ptr_d;
      sda_low_q <= sda_low_d;
      wr_seen_q <= wr_seen_d;
      ctl_lo_q  <= ctl_lo_d;
      ctl_hi_q  <= ctl_hi_d;
      scl_q     <= scl_in;
      sda_q     <= sda_in;
    end
  end

  assign begin_cmd = sub_valid && ({shift_q, ctl_lo_q} == SUB_BEGIN);
  assign end_cmd   = sub_valid && ({shift_q, ctl_lo_q} == SUB_END);

  always_comb
  begin
    g_state_d = g_state_q;
    g_cnt_d   = g_cnt_q;
    init_d    = init_q;
    done_d    = done_q;
    svc_end_d = svc_end_q;
    total_d   = total_q;
    life_d    = 1'b0;
    thr_d     = 1'b0;
    // set wins over the flags read in the same cycle
    alert_d   = alert_q & ~flags_read;
    if (g_state_q == G_ACTIVE && mode == MODE_CHARGE && discharge_tick_in)
    begin
      total_d = total_q + 16'h0001;
    end
    case (g_state_q)
      G_INIT:
      begin
        if (g_cnt_q == GW'(INIT_CYC - 1))
        begin
          g_state_d = G_IDLE;
          init_d    = 1'b1;
          alert_d   = 1'b1;
        end
        else
        begin
          g_cnt_d = g_cnt_q + 1'b1;
        end
      end
      G_IDLE, G_ACTIVE:
      begin
        if (begin_cmd)
        begin
          g_state_d = G_ACTIVE;
          total_d   = CHARGE_RESET;
          done_d    = 1'b0;
          svc_end_d = 1'b0;
        end
        else if (end_cmd)
        begin
          // health mode may end without a prior begin
          g_state_d = G_FINISH;
          g_cnt_d   = '0;
          done_d    = 1'b0;
        end
      end
      G_FINISH:
      begin
        // begin and end are dropped here, done stays clear
        if (g_cnt_q == GW'(FINISH_CYC - 1))
        begin
          g_state_d = G_IDLE;
          done_d    = 1'b1;
          alert_d   = 1'b1;
          life_d    = (mode == MODE_HEALTH);
          thr_d     = (mode == MODE_HEALTH);
          if (mode == MODE_SERVICE)
          begin
            svc_end_d = service_end_decision_in;
          end
        end
        else
        begin
          g_cnt_d = g_cnt_q + 1'b1;
        end
      end
      default:
      begin
        g_state_d = G_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst)
    begin
      g_state_q <= G_INIT;
      g_cnt_q   <= '0;
      init_q    <= 1'b0;
      done_q    <= 1'b0;
      svc_end_q <= 1'b0;
      alert_q   <= 1'b0;
      life_q    <= 1'b0;
      thr_q     <= 1'b0;
      total_q   <= CHARGE_RESET;
    end
    else
    begin
      g_state_q <= g_state_d;
      g_cnt_q   <= g_cnt_d;
      init_q    <= init_d;
      done_q    <= done_d;
      svc_end_q <= svc_end_d;
      alert_q   <= alert_d;
      life_q    <= life_d;
      thr_q     <= thr_d;
      total_q   <= total_d;
    end
  end

  // device never stretches the clock
  assign scl_out                 = 1'b0;
  assign scl_oe_n_out            = 1'b1;
  assign sda_out                 = 1'b0;
  assign sda_oe_n_out            = ~(sda_low_q & ~bus_release);
  assign alert_n_out             = ~alert_q;
  assign init_complete_flag_out  = init_q;
  assign gauge_done_out          = done_q;
  assign service_end_flag_out    = svc_end_q;
  assign gauging_active_out      = (g_state_q == G_ACTIVE);
  // pin default of zero selects the shipped charge-total mode
  assign calibration_allowed_out = (mode == MODE_CHARGE);
  assign lifetime_store_out      = life_q;
  assign threshold_check_out     = thr_q;
  assign bus_released_out        = bus_release;
  assign serial_sleep_out        = serial_sleep;

endmodule
`default_nettype wire

/* File: pcg_host_model.sv */
// host side serial master model with open-drain clock and data
`timescale 1ns/100ps
`default_nettype none
module pcg_host_model
  import pcg_pkg::*;
(
  // clock
  input  wire logic clk_sys_in,
  // resolved data line
  input  wire logic sda_in,
  // host drive, 1 means released to the pull-up
  output logic      scl_out,
  output logic      sda_out
);
  // clock stands high between frames
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic hold(input logic b);
    sda_out = b;
    tick(1);
  endtask

  task automatic put_bit(input logic b);
    sda_out = b;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    scl_out = 1'b0;
    tick(2);
  endtask

  task automatic get_bit(output logic b);
    sda_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    b = sda_in;
    tick(2);
    scl_out = 1'b0;
    tick(2);
  endtask

  task automatic start();
    sda_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sda_out = 1'b0;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b1;
    tick(4);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(~more);
  endtask

  task automatic wr(input logic [6:0] c, input logic [7:0] d,
                    output logic [2:0] a);
    start();
    wbyte({DEV_ADDR, 1'b0}, a[2]);
    wbyte({1'b0, c}, a[1]);
    wbyte(d, a[0]);
    stop();
  endtask

  // two-byte incremental read, first byte in the upper half
  task automatic rd2(input logic [6:0] c, output logic [15:0] q,
                     output logic ok);
    logic [2:0] a;
    start();
    wbyte({DEV_ADDR, 1'b0}, a[2]);
    wbyte({1'b0, c}, a[1]);
    start();
    wbyte({DEV_ADDR, 1'b1}, a[0]);
    rbyte(1'b1, q[15:8]);
    rbyte(1'b0, q[7:0]);
    stop();
    ok = &a;
  endtask
endmodule
`default_nettype wire

/* File: pcg_sequencer_sva.sv */
// port-level assertions for the gauge host sequencer
`timescale 1ns/100ps
`default_nettype none
module pcg_sequencer_sva #(
  parameter int INIT_CYC = 10
) (
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  // watched ports
  input wire logic       gauge_power_enable_in,
  input wire logic [1:0] gauging_mode_select_in,
  input wire logic       scl_in,
  input wire logic       scl_oe_n_out,
  input wire logic       sda_oe_n_out,
  input wire logic       alert_n_out,
  input wire logic       init_complete_flag_out,
  input wire logic       gauge_done_out,
  input wire logic       gauging_active_out,
  input wire logic       calibration_allowed_out,
  input wire logic       lifetime_store_out,
  input wire logic       bus_released_out,
  input wire logic       serial_sleep_out
);
  // one edge of slack on where the init count is read
  localparam int INIT_HI = INIT_CYC + 1;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_scl_never_held: assert property (scl_oe_n_out)
    else $error("clock line driven");
  a_release_frees_sda: assert property (
    bus_released_out |-> sda_oe_n_out)
    else $error("data driven while released");
  a_sleep_after_release: assert property (
    $rose(serial_sleep_out) |-> $past(bus_released_out))
    else $error("sleep without release");
  a_off_clears_state: assert property (
    !gauge_power_enable_in |=>
      alert_n_out && !init_complete_flag_out && !gauge_done_out)
    else $error("state kept while off");
  a_init_after_power: assert property (
    gauge_power_enable_in &&
    ($past(reset_in) || !$past(gauge_power_enable_in)) |->
      !init_complete_flag_out ##[INIT_CYC:INIT_HI] init_complete_flag_out)
    else $error("init flag late or early");
  a_init_pulls_alert: assert property (
    $rose(init_complete_flag_out) |-> !alert_n_out)
    else $error("init without alert");
  a_done_pulls_alert: assert property (
    $rose(gauge_done_out) |-> !alert_n_out && !gauging_active_out)
    else $error("done without alert");
  a_active_not_done: assert property (
    gauging_active_out |-> !gauge_done_out)
    else $error("done flag while gauging");
  a_lifetime_in_health: assert property (
    lifetime_store_out |-> gauging_mode_select_in == 2'h1)
    else $error("lifetime store outside health mode");
  a_calib_charge_mode: assert property (
    calibration_allowed_out == (gauging_mode_select_in == 2'h0 ||
                                gauging_mode_select_in == 2'h3))
    else $error("calibration gate wrong");
  a_drive_on_low_scl: assert property (
    $changed(sda_oe_n_out) && !bus_released_out && gauge_power_enable_in
      |-> !$past(scl_in))
    else $error("data drive changed while clock high");

  c_done: cover property ($rose(gauge_done_out));
  c_sleep: cover property ($rose(serial_sleep_out));
  c_lifetime: cover property (lifetime_store_out);
  c_ack: cover property (!sda_oe_n_out ##1 sda_oe_n_out);
endmodule
bind pcg_sequencer pcg_sequencer_sva #(.INIT_CYC(INIT_CYC)) u_sva (
  .clk_sys_in, .reset_in, .gauge_power_enable_in, .gauging_mode_select_in,
  .scl_in, .scl_oe_n_out, .sda_oe_n_out, .alert_n_out,
  .init_complete_flag_out, .gauge_done_out, .gauging_active_out,
  .calibration_allowed_out, .lifetime_store_out, .bus_released_out,
  .serial_sleep_out);
`default_nettype wire

/* File: pcg_sequencer_tb.sv */
// self-checking bench for the gauge host sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
  begin \
    checks++; \
    if ((s) !== (e)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", n, e, s); \
    end \
  end
module pcg_sequencer_tb;
  import pcg_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pwr = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic        dtick = 1'b0;
  logic [7:0]  hp = 8'h4b;
  logic        sed = 1'b1;
  logic        scl_h, sda_h, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic        alert_n, init_f, done_f, eos_f, active, cal;
  logic        lts, thr, rel, slp, ok;
  logic [15:0] q;
  logic [3:0]  a;
  logic [2:0]  wa;
  int          bad_count = 0;
  int          checks = 0;
  int          ls_cnt = 0;
  int          th_cnt = 0;
  // pull-ups: a line is low only while some party drives it low
  wire logic   scl_w = scl_h & (scl_oe_n | scl_o);
  wire logic   sda_w = sda_h & (sda_oe_n | sda_o);

  pcg_host_model u_host (.clk_sys_in(clk), .sda_in(sda_w),
                         .scl_out(scl_h), .sda_out(sda_h));
  pcg_sequencer #(.BUS_LOW_CYC(300), .INIT_CYC(10), .FINISH_CYC(800)) u_dut (
    .clk_sys_in(clk), .reset_in(rst), .gauge_power_enable_in(pwr),
    .gauging_mode_select_in(mode), .discharge_tick_in(dtick),
    .health_percent_in(hp), .service_end_decision_in(sed),
    .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o),
    .scl_oe_n_out(scl_oe_n), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .alert_n_out(alert_n), .init_complete_flag_out(init_f),
    .gauge_done_out(done_f), .service_end_flag_out(eos_f),
    .gauging_active_out(active), .calibration_allowed_out(cal),
    .lifetime_store_out(lts), .threshold_check_out(thr),
    .bus_released_out(rel), .serial_sleep_out(slp));

  initial
    forever #25 clk = ~clk;

  always @(posedge clk)
  begin
    if (lts === 1'b1) ls_cnt++;
    if (thr === 1'b1) th_cnt++;
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_alert();
    int i;
    for (i = 0; i < 3000 && alert_n !== 1'b0; i++)
      u_host.tick(1);
    if (i == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic sub(input logic [15:0] s);
    u_host.wr(CTL_LO_ADDR, s[7:0], wa);
    u_host.wr(CTL_HI_ADDR, s[15:8], wa);
  endtask

  // power is only dropped between update cycles, mode set while off
  task automatic cycle_power(input logic [1:0] m);
    pwr = 1'b0;
    mode = m;
    u_host.tick(3);
    `CHK("off state", 3'h4, {alert_n, init_f, done_f})
    pwr = 1'b1;
    wait_alert();
    u_host.rd2(FLAGS_ADDR, q, ok);
  endtask

  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      mode = m[1:0];
      rst = (m < 2);
      u_host.tick(1);
      `CHK("calibration gate", (m == 0 || m == 3), cal)
    end
    mode = 2'h0;
    wait_alert();
    `CHK("init flag", 1'b1, init_f)
    u_host.rd2(FLAGS_ADDR, q, ok);
    `CHK("flags", 8'h01, q[15:8])
    `CHK("read acks", 1'b1, ok)
    `CHK("alert cleared", 1'b1, alert_n)
    u_host.start();
    u_host.wbyte({DEV_ADDR, 1'b0}, a[3]);
    u_host.wbyte(8'h10, a[2]);
    u_host.wbyte(8'h5a, a[1]);
    u_host.wbyte(8'h33, a[0]);
    u_host.stop();
    `CHK("surplus acks", 4'he, a)
    u_host.rd2(7'h10, q, ok);
    `CHK("surplus data", 16'h5a00, q)
    u_host.wr(7'h7f, 8'hc3, wa);
    u_host.wr(7'h00, 8'h3c, wa);
    `CHK("write acks", 3'h7, wa)
    u_host.rd2(7'h7f, q, ok);
    `CHK("wrap read", 16'hc33c, q)
    u_host.start();
    u_host.wbyte({DEV_ADDR, 1'b0}, a[1]);
    u_host.wbyte(8'h80, a[0]);
    u_host.stop();
    `CHK("high command acks", 2'h2, a[1:0])
    sub(SUB_BEGIN);
    `CHK("gauging", 1'b1, active)
    repeat (5)
    begin
      dtick = 1'b1;
      u_host.tick(1);
      dtick = 1'b0;
      u_host.tick(2);
    end
    u_host.rd2(CHARGE_LO_ADDR, q, ok);
    `CHK("charge total", 16'h0500, q)
    u_host.rd2(HEALTH_ADDR, q, ok);
    `CHK("no health in charge mode", 8'h00, q[15:8])
    sub(SUB_END);
    sub(SUB_BEGIN);
    wait_alert();
    `CHK("done, begin ignored", 2'h2, {done_f, active})
    u_host.rd2(CHARGE_LO_ADDR, q, ok);
    `CHK("final charge total", 16'h0500, q)
    u_host.rd2(FLAGS_ADDR, q, ok);
    `CHK("done flags", 8'h03, q[15:8])
    `CHK("no lifetime store", 0, ls_cnt)
    cycle_power(2'h1);
    hp = 8'h64;
    u_host.rd2(7'h10, q, ok);
    `CHK("memory lost", 8'h00, q[15:8])
    u_host.rd2(HEALTH_ADDR, q, ok);
    `CHK("health", 8'h64, q[15:8])
    sub(SUB_END);
    wait_alert();
    u_host.tick(1);
    `CHK("lifetime store", 1, ls_cnt)
    `CHK("threshold check", 1, th_cnt)
    cycle_power(2'h2);
    sub(SUB_BEGIN);
    sub(SUB_END);
    wait_alert();
    u_host.rd2(FLAGS_ADDR, q, ok);
    `CHK("service flags", 8'h07, q[15:8])
    `CHK("service end", 1'b1, eos_f)
    sed = 1'b0;
    sub(SUB_BEGIN);
    sub(SUB_END);
    wait_alert();
    `CHK("service end low", 1'b0, eos_f)
    u_host.hold(1'b0);
    u_host.tick(310);
    `CHK("stuck release", 3'h7, {rel, slp, sda_oe_n})
    u_host.hold(1'b1);
    u_host.tick(4);
    `CHK("bus back", 2'h0, {rel, slp})
    print_verdict();
  end
endmodule
`default_nettype wire
